// file: pclk_sel_pkg.sv
// Shared constants and code-to-divider table for the pixel clock select control
package pclk_sel_pkg;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int          CODE_W     = 4;
  localparam int          DIV_W      = 8;
  localparam logic [3:0]  CODE_RESET = 4'h0;

  // ----------------------------------------------------------------------
  // Divider table: entry = {reference ratio N, feedback ratio M}
  // Output frequency is the crystal frequency times M / N
  // ----------------------------------------------------------------------
  localparam logic [15:0] RATIO_TABLE [0:15] = '{
    16'h1D33,  // 0000 25.175 MHz
    16'h2E5B,  // 0001 28.322 MHz
    16'h0D3B,  // 0010 65.000 MHz
    16'h1645,  // 0011 44.900 MHz
    16'h5A59,  // 0100 14.161 MHz
    16'h4253,  // 0101 18.000 MHz
    16'h225F,  // 0110 40.000 MHz
    16'h1D49,  // 0111 36.000 MHz
    16'h1D33,  // 1000 25.175 MHz
    16'h2E5B,  // 1001 28.322 MHz
    16'h0931,  // 1010 78.000 MHz
    16'h0D3B,  // 1011 65.000 MHz
    16'h225F,  // 1100 40.000 MHz
    16'h0207,  // 1101 50.000 MHz
    16'h0516,  // 1110 63.000 MHz
    16'h23B0   // 1111 72.000 MHz
  };

  // Reference divider ratio for a frequency code
  function automatic logic [7:0] ref_ratio(input logic [3:0] code);
    ref_ratio = RATIO_TABLE[code][15:8];
  endfunction : ref_ratio

  // Feedback divider ratio for a frequency code
  function automatic logic [7:0] fb_ratio(input logic [3:0] code);
    fb_ratio = RATIO_TABLE[code][7:0];
  endfunction : fb_ratio

endpackage : pclk_sel_pkg

// file: pll_div_counter.sv
// Programmable divider counter with synchronous clear and terminal count pulse
`timescale 1ns/1ps
module pll_div_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // Control
  input  wire logic         clear_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] ratio_i,
  // Status
  output logic      [W-1:0] count_o,
  output logic              tc_o
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // Terminal count on the input edge that completes one divided period
  assign tc_o    = tick_i && !clear_i && (count_q == ratio_i - W'(1));
  assign count_o = count_q;

  // Next count: clear pins it at zero, wrap on terminal count
  always_comb begin
    count_d = count_q;
    if (clear_i) begin
      count_d = '0;
    end else if (tc_o) begin
      count_d = '0;
    end else if (tick_i) begin
      count_d = count_q + W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : pll_div_counter

// file: pixel_clock_select_control.sv
// Frequency code capture, divider control and phase comparator of the pixel clock PLL
//
// What this block does
// - A four-bit code with bit 3 as MSB selects the synthesised output frequency.
// - The select inputs are captured into the code register on the strobe rising edge.
// - While the strobe is high the charge pump output is high impedance.
// - While the strobe is high both reference and feedback dividers sit at zero.
// - When the strobe falls both dividers count from zero and the pump is re-enabled together.
// - After release the first divider to reach terminal count sets the correction direction.
// - Power-on-clear loads the all-zeros code regardless of select inputs and strobe.
// - With bit 3 low, codes 0 to 7 pick 25.175, 28.322, 65, 44.9, 14.161, 18, 40, 36 MHz.
// - A low polarity select input inverts the sense of the charge pump correction.
`timescale 1ns/1ps
module pixel_clock_select_control
  import pclk_sel_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Frequency select pins from the display controller
  input  wire logic        freq_code_bit0_i,
  input  wire logic        freq_code_bit1_i,
  input  wire logic        freq_code_bit2_i,
  input  wire logic        freq_code_bit3_i,
  input  wire logic        strobe_i,
  // Loop clocks and polarity pin
  input  wire logic        crystal_in_i,
  input  wire logic        vco_clock_i,
  input  wire logic        pump_polarity_select_i,
  // Charge pump drive and status
  output logic             pump_o,
  output logic             pump_oe_o,
  output logic [3:0]       freq_code_o,
  output logic [7:0]       ref_ratio_o,
  output logic [7:0]       fb_ratio_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Stage 1 is read only by stage 2; stage 3 exists for edge detection
  logic [7:0] sync1_q, sync1_d;
  logic [7:0] sync2_q, sync2_d;
  logic [2:0] sync3_q, sync3_d;
  logic [3:0] code_s;
  logic       strobe_s, xtal_s, vco_s, pol_s;
  logic       strobe_rise, ref_tick, fb_tick;

  always_comb begin
    sync1_d = {pump_polarity_select_i, vco_clock_i, crystal_in_i, strobe_i,
               freq_code_bit3_i, freq_code_bit2_i, freq_code_bit1_i, freq_code_bit0_i};
    sync2_d = sync1_q;
    sync3_d = sync2_q[6:4];
  end

  // Polarity pin resets high, matching its internal pull-up
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q <= 8'h80;
      sync2_q <= 8'h80;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
    end
  end

  // Synchronised levels and single-cycle edge events
  assign code_s      = sync2_q[3:0];
  assign strobe_s    = sync2_q[4];
  assign xtal_s      = sync2_q[5];
  assign vco_s       = sync2_q[6];
  assign pol_s       = sync2_q[7];
  assign strobe_rise = strobe_s && !sync3_q[0];
  assign ref_tick    = xtal_s && !sync3_q[1];
  assign fb_tick     = vco_s && !sync3_q[2];

  // ----------------------------------------------------------------------
  // Frequency code register
  // ----------------------------------------------------------------------
  // Code and strobe share the same sync depth, so pin setup and hold carry over
  logic [3:0] code_q, code_d;

  always_comb begin
    code_d = code_q;
    if (strobe_rise) begin
      code_d = code_s;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_q <= CODE_RESET;
    end else begin
      code_q <= code_d;
    end
  end

  // Table lookup covers primary and alternate sets
  assign freq_code_o = code_q;
  assign ref_ratio_o = ref_ratio(code_q);
  assign fb_ratio_o  = fb_ratio(code_q);

  // ----------------------------------------------------------------------
  // Reference and feedback dividers
  // ----------------------------------------------------------------------
  logic [7:0] ref_cnt, fb_cnt;
  logic       ref_tc, fb_tc;

  // Both dividers share the strobe as clear, so they restart on the same edge
  pll_div_counter #(.W(DIV_W)) u_ref_div (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .clear_i   (strobe_s),
    .tick_i    (ref_tick),
    .ratio_i   (ref_ratio_o),
    .count_o   (ref_cnt),
    .tc_o      (ref_tc)
  );

  pll_div_counter #(.W(DIV_W)) u_fb_div (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .clear_i   (strobe_s),
    .tick_i    (fb_tick),
    .ratio_i   (fb_ratio_o),
    .count_o   (fb_cnt),
    .tc_o      (fb_tc)
  );

  // ----------------------------------------------------------------------
  // Phase comparator
  // ----------------------------------------------------------------------
  // Tri-state phase-frequency detector; a tie cancels so no net correction
  logic up_q, up_d;
  logic dn_q, dn_d;

  always_comb begin
    up_d = up_q;
    dn_d = dn_q;
    if (strobe_s) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end else begin
      if (ref_tc) begin
        up_d = 1'b1;
      end
      if (fb_tc) begin
        dn_d = 1'b1;
      end
      if (up_d && dn_d) begin
        up_d = 1'b0;
        dn_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= up_d;
      dn_q <= dn_d;
    end
  end

  // ----------------------------------------------------------------------
  // Charge pump drive
  // ----------------------------------------------------------------------
  // Pump is released on the same synced strobe level that releases the dividers
  always_comb begin
    pump_oe_o = (up_q ^ dn_q) && !strobe_s;
    pump_o    = up_q ? pol_s : !pol_s;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_strobe_held;
    strobe_s [*2];
  endsequence

  sequence s_release;
    !strobe_s && $past(strobe_s);
  endsequence

  a_code_capture: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    strobe_rise |=> code_q == $past(code_s))
    else $error("code not captured on strobe rise");

  a_code_stable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !strobe_rise |=> $stable(code_q))
    else $error("code changed without strobe rise");

  a_poc_code: assert property (@(posedge clk_i)
    $fell(sys_rst_i) |-> code_q == CODE_RESET)
    else $error("code not cleared by power-on-clear");

  // Judged from the strobe pin two edges back, so the check does not reuse the gating term
  a_pump_hiz: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(strobe_i, 2) |-> !pump_oe_o)
    else $error("pump driven while strobe high");

  a_div_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_strobe_held |-> ref_cnt == 8'h00 && fb_cnt == 8'h00 && !up_q && !dn_q)
    else $error("dividers not held at zero");

  a_release_sync: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_release |-> ref_cnt == 8'h00 && fb_cnt == 8'h00)
    else $error("dividers not at zero on release");

  a_up_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !strobe_s && ref_tc && !fb_tc && !up_q && !dn_q |=> up_q && !dn_q && pump_oe_o == !strobe_s)
    else $error("reference win did not raise up");

  a_dn_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !strobe_s && fb_tc && !ref_tc && !up_q && !dn_q |=> dn_q && !up_q)
    else $error("feedback win did not raise down");

  a_pump_sense: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pump_oe_o |-> pump_o == (up_q ~^ $past(pump_polarity_select_i, 2)))
    else $error("pump polarity wrong");

  a_ratio_map: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    code_q == 4'h2 |-> ref_ratio_o == 8'h0D && fb_ratio_o == 8'h3B)
    else $error("65 MHz code maps to wrong ratios");

endmodule : pixel_clock_select_control

// file: pclk_ctl_model.sv
// Display controller and loop clock source model for the pixel clock select control
`timescale 1ns/1ps
module pclk_ctl_model (
  // Clock
  input  wire logic       clk_i,
  // Loop clock half periods in system clocks
  input  wire logic [3:0] ref_half_i,
  input  wire logic [3:0] vco_half_i,
  // Pins into the block
  output logic [3:0]      code_o,
  output logic            strobe_o,
  output logic            crystal_o,
  output logic            vco_o
);
  int ref_cnt = 0;
  int vco_cnt = 0;

  // ----------------------------------------------------------------------
  // Sources and pins
  // ----------------------------------------------------------------------
  initial begin
    code_o    = 4'h0;
    strobe_o  = 1'b0;
    crystal_o = 1'b0;
    vco_o     = 1'b0;
  end

  // Square sources; half periods of two or more keep them sampleable
  always @(posedge clk_i) begin
    ref_cnt <= (ref_cnt + 1 >= int'(ref_half_i)) ? 0 : ref_cnt + 1;
    vco_cnt <= (vco_cnt + 1 >= int'(vco_half_i)) ? 0 : vco_cnt + 1;
    if (ref_cnt + 1 >= int'(ref_half_i)) crystal_o <= ~crystal_o;
    if (vco_cnt + 1 >= int'(vco_half_i)) vco_o <= ~vco_o;
  end

  // Strobed select: code settles two clocks ahead and is held past the rise
  task automatic raise(input logic [3:0] c);
    code_o <= c;
    repeat (2) @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : raise

  task automatic drop();
    strobe_o <= 1'b0;
  endtask : drop

  // Noise on the pins while no capture is meant
  task automatic scramble(input logic [3:0] c);
    code_o <= c;
  endtask : scramble
endmodule : pclk_ctl_model

// file: tb.sv
// Self-checking testbench of the pixel clock select control
`timescale 1ns/1ps
module tb;
  import pclk_sel_pkg::*;
  logic       clk_i;
  logic       sys_rst_i;
  logic       pol;
  logic [3:0] ref_half;
  logic [3:0] vco_half;
  logic [3:0] code;
  logic       strobe;
  logic       xtal;
  logic       vco;
  logic       pump_o;
  logic       pump_oe_o;
  logic [3:0] freq_code_o;
  logic [7:0] ref_ratio_o;
  logic [7:0] fb_ratio_o;
  int         n_errors = 0;
  int         tests_run = 0;
  int         cycles = 0;
  int         k;
  logic [3:0] exp_code;
  logic       exp_up;

  // ----------------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------------
  pclk_ctl_model u_ctl (.clk_i(clk_i), .ref_half_i(ref_half), .vco_half_i(vco_half),
    .code_o(code), .strobe_o(strobe), .crystal_o(xtal), .vco_o(vco));
  pixel_clock_select_control uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .freq_code_bit0_i(code[0]), .freq_code_bit1_i(code[1]), .freq_code_bit2_i(code[2]),
    .freq_code_bit3_i(code[3]), .strobe_i(strobe), .crystal_in_i(xtal), .vco_clock_i(vco),
    .pump_polarity_select_i(pol), .pump_o(pump_o), .pump_oe_o(pump_oe_o),
    .freq_code_o(freq_code_o), .ref_ratio_o(ref_ratio_o), .fb_ratio_o(fb_ratio_o));

  // ----------------------------------------------------------------------
  // Clock, watchdog, checking
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Whole run needs some 1100 cycles; a hang stops well past that
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Model of the captured code and its ratio pair
  task automatic check_code();
    check("code", {12'h000, freq_code_o}, {12'h000, exp_code});
    check("ref ratio", {8'h00, ref_ratio_o}, {8'h00, RATIO_TABLE[exp_code][15:8]});
    check("fb ratio", {8'h00, fb_ratio_o}, {8'h00, RATIO_TABLE[exp_code][7:0]});
  endtask : check_code

  task automatic final_report();
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h2be66602));
    sys_rst_i = 1'b1;
    pol       = 1'b1;
    ref_half  = 4'd3;
    vco_half  = 4'd2;
    exp_code  = 4'h0;
    @(posedge clk_i);
    u_ctl.scramble(4'hA);
    repeat (11) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    check_code();
    check("oe at reset", {15'h0, pump_oe_o}, 16'h0000);
    // Every code, then noise on the pins with strobe held high and low
    for (int c = 0; c < 16; c++) begin
      @(posedge clk_i);
      u_ctl.raise(c[3:0]);
      exp_code = c[3:0];
      @(negedge clk_i);
      check_code();
      check("oe in strobe", {15'h0, pump_oe_o}, 16'h0000);
      @(posedge clk_i);
      u_ctl.scramble(4'($urandom));
      repeat (4) @(posedge clk_i);
      u_ctl.drop();
      repeat (3) @(posedge clk_i);
      u_ctl.scramble(4'($urandom));
      repeat (4) @(negedge clk_i);
      check_code();
    end
    // Second reset in mid-run clears the code again
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    exp_code = 4'h0;
    repeat (2) @(negedge clk_i);
    check_code();
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Direction of first correction: code 0 gives N 29, M 51, VCO period 4
    for (int t = 0; t < 4; t++) begin
      @(posedge clk_i);
      ref_half <= t[0] ? 4'd3 : 4'd5;
      pol      <= t[1];
      u_ctl.raise(4'h0);
      @(negedge clk_i);
      check("oe held", {15'h0, pump_oe_o}, 16'h0000);
      @(posedge clk_i);
      u_ctl.drop();
      k = 0;
      while (pump_oe_o !== 1'b1 && k < 600) begin
        @(negedge clk_i);
        k++;
      end
      check("pump enable", {15'h0, k < 600}, 16'h0001);
      // Winner from N times reference period against M times VCO period
      exp_up = int'(RATIO_TABLE[0][15:8]) * (t[0] ? 6 : 10) < int'(RATIO_TABLE[0][7:0]) * 4;
      check("pump dir", {15'h0, pump_o}, {15'h0, exp_up ~^ t[1]});
    end
    final_report();
  end
endmodule : tb
